// ==== src/mmt_ctrl.sv ====
/*
 * Management control and status logic: 2-wire serial slave, identification tail, user page,
 * interrupt flags and masks, reset pin filter, initialization and low-power control.
 * Assumes all pins are asynchronous to i_mclk and that the bus clock is far slower than i_mclk.
 */
`timescale 1ns/1ps
module mmt_ctrl #(
	parameter int                                  INIT_CYC    = mmt_pkg::T_INIT_MS * (mmt_pkg::NS_PER_MS / mmt_pkg::CLK_NS),
	parameter logic [7:0]                          DIAG_TYPE   = 8'h00,
	parameter logic [7:0]                          ENH_OPTS    = 8'h00,
	parameter logic [mmt_pkg::EXT_LOW_N-1:0][7:0]  EXT_ID_LOW  = '0
) (
	input  wire logic                i_mclk,             // system clock, 40 MHz
	input  wire logic                i_rst,              // power-on reset, async, high
	input  wire logic                i_reset_n_pin,      // host reset pin, low
	input  wire logic                i_module_select_n,  // module select pin, low
	input  wire logic                i_low_power_pin,    // low-power request pin
	input  wire mmt_pkg::mmt_cond_t  i_cond,             // raw flag conditions
	input  wire logic                i_scl,              // serial bus clock
	input  wire logic                i_sda_in,           // serial data line level
	output logic                     o_sda_out,          // serial data drive value
	output logic                     o_sda_oe,           // serial data drive enable
	output logic                     o_interrupt_out_n,  // interrupt pin, low
	output logic                     o_low_power,        // power level select
	output logic                     o_ready             // fully functional
);

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	// sum of covered bytes
	function automatic logic [7:0] ext_csum();
		logic [7:0] s;
		s = DIAG_TYPE + ENH_OPTS;
		for (int i = 0; i < mmt_pkg::EXT_LOW_N; i++) begin
			s = s + EXT_ID_LOW[i];
		end
		return s;
	endfunction : ext_csum

	function automatic logic [7:0] rd_byte(input mmt_pkg::mmt_state_t s, input logic [7:0] a);
		logic [7:0] v;
		logic [7:0] idx;
		v   = 8'h00;
		idx = a - mmt_pkg::A_EXT_ID_LO;
		if (!a[7]) begin
			unique case (a)
				mmt_pkg::A_STATUS:   v = {7'h00, ~s.ready};
				mmt_pkg::A_FLAG_LOS: v = {4'h0, s.flags.los};
				mmt_pkg::A_FLAG_TX:  v = {4'h0, s.flags.tx_fault};
				mmt_pkg::A_FLAG_ALM: v = s.flags.alarm;
				mmt_pkg::A_PWR_CTRL: v = {6'h00, s.pwr_ctrl};
				mmt_pkg::A_MASK_LOS: v = {4'h0, s.mask.los};
				mmt_pkg::A_MASK_TX:  v = {4'h0, s.mask.tx_fault};
				mmt_pkg::A_MASK_ALM: v = s.mask.alarm;
				mmt_pkg::A_PAGE_SEL: v = s.page;
				default:             v = 8'h00;
			endcase
		end else if (s.page == mmt_pkg::PAGE_USER) begin
			v = s.user_mem[a[6:0]];
		end else if (s.page == mmt_pkg::PAGE_ID && a >= mmt_pkg::A_EXT_ID_LO) begin
			unique case (a)
				mmt_pkg::A_DIAG_TYPE: v = DIAG_TYPE;
				mmt_pkg::A_ENH_OPTS:  v = ENH_OPTS;
				mmt_pkg::A_RSVD_ID:   v = 8'h00;
				mmt_pkg::A_EXT_CSUM:  v = ext_csum();
				default:              v = EXT_ID_LOW[idx[4:0]];
			endcase
		end
		return v;
	endfunction : rd_byte

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	mmt_pkg::mmt_state_t q, d;

	localparam mmt_pkg::mmt_state_t RST_STATE = '{
		scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1, sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1,
		rstn_m: 1'b1, rstn_s: 1'b1, mseln_m: 1'b1, mseln_s: 1'b1,
		intr_n: 1'b1, bus_st: mmt_pkg::S_IDLE, default: '0
	};

	logic start, stop, rise, fall, sel;
	logic [7:0] rdv;
	logic [7:0] stat_byte;
	assign rise  = q.scl_s & ~q.scl_p;
	assign fall  = ~q.scl_s & q.scl_p;
	assign start = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
	assign stop  = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
	assign sel   = ~q.mseln_s;
	assign rdv   = rd_byte(q, q.ptr);
	// status byte as the host would read it, for the init check
	assign stat_byte = rd_byte(q, mmt_pkg::A_STATUS);

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		d = q;
		// pin synchronisers, second stage feeds logic
		{d.scl_s, d.scl_m} = {q.scl_m, i_scl};
		{d.sda_s, d.sda_m} = {q.sda_m, i_sda_in};
		{d.rstn_s, d.rstn_m} = {q.rstn_m, i_reset_n_pin};
		{d.mseln_s, d.mseln_m} = {q.mseln_m, i_module_select_n};
		{d.lp_s, d.lp_m} = {q.lp_m, i_low_power_pin};
		d.cond_m = i_cond;
		d.cond_s = q.cond_m;
		d.scl_p  = q.scl_s;
		d.sda_p  = q.sda_s;

		if (q.rstn_s) begin
			d.rst_cnt = '0;
		end else if (q.rst_cnt != mmt_pkg::RST_MIN_CYC) begin
			d.rst_cnt = q.rst_cnt + 1'b1;
		end
		if (q.rst_cnt == mmt_pkg::RST_MIN_CYC) begin
			d.busy = 1'b1;
		end else if (q.busy && q.rstn_s) begin
			d.busy = 1'b0;
		end

		// init timer restarts at reset release
		if (q.busy) begin
			d.init_cnt  = '0;
			d.ready     = 1'b0;
			d.init_pend = 1'b0;
		end else if (!q.ready) begin
			d.init_cnt = q.init_cnt + 1'b1;
			if (q.init_cnt == mmt_pkg::INIT_W'(INIT_CYC - 1)) begin
				d.ready     = 1'b1;
				d.init_pend = 1'b1;
			end
		end

		// clears applied at stop; set wins over clear
		if (q.busy) begin
			d.flags = '0;
		end else begin
			d.flags = mmt_pkg::mmt_cond_t'((q.flags & ~(stop ? q.clr : '0)) | q.cond_s);
		end
		if (stop || q.busy) begin
			d.clr     = '0;
			d.stat_rd = 1'b0;
			if (q.stat_rd && !(q.busy || (!q.ready && d.ready))) begin
				d.init_pend = 1'b0;
			end
		end

		d.intr_n = ~(|(q.flags & ~q.mask) | q.init_pend);

		d.low_pwr = q.lp_s | (q.pwr_ctrl[mmt_pkg::BIT_PWR_OVR] & q.pwr_ctrl[mmt_pkg::BIT_PWR_SET]);

		// deselect or stop ends any transfer
		if (q.busy || stop || (!sel && q.bus_st != mmt_pkg::S_IDLE)) begin
			d.bus_st = mmt_pkg::S_IDLE;
			d.sda_oe = 1'b0;
		end else if (start) begin
			d.bus_st  = mmt_pkg::S_ADDR;
			d.bit_cnt = '0;
			d.sda_oe  = 1'b0;
		end else begin
			unique case (q.bus_st)
				mmt_pkg::S_IDLE: begin
				end
				mmt_pkg::S_ADDR: begin
					if (rise) begin
						d.shreg   = {q.shreg[6:0], q.sda_s};
						d.bit_cnt = q.bit_cnt + 4'h1;
					end else if (fall && q.bit_cnt == mmt_pkg::BITS_BYTE) begin
						// fixed device address; answers once reset released
						if (q.shreg[7:1] == mmt_pkg::DEV_ADDR && sel) begin
							d.bus_st = mmt_pkg::S_ACKA;
							d.sda_oe = 1'b1;
							d.rw     = q.shreg[0];
						end else begin
							d.bus_st = mmt_pkg::S_IDLE;
						end
					end
				end
				mmt_pkg::S_ACKA: begin
					if (fall) begin
						d.bit_cnt = '0;
						if (q.rw) begin
							d.bus_st = mmt_pkg::S_RD;
							d.shreg  = rdv;
							d.sda_oe = ~rdv[7];
						end else begin
							d.bus_st = mmt_pkg::S_WR;
							d.sda_oe = 1'b0;
							d.first  = 1'b1;
						end
					end
				end
				mmt_pkg::S_WR: begin
					if (rise) begin
						d.shreg   = {q.shreg[6:0], q.sda_s};
						d.bit_cnt = q.bit_cnt + 4'h1;
					end else if (fall && q.bit_cnt == mmt_pkg::BITS_BYTE) begin
						d.bus_st = mmt_pkg::S_ACKW;
						d.sda_oe = 1'b1;
						d.first  = 1'b0;
						if (q.first) begin
							d.ptr = q.shreg;
						end else begin
							d.ptr = q.ptr + 8'h01;
							// control takes effect before the stop
							if (!q.ptr[7]) begin
								unique case (q.ptr)
									mmt_pkg::A_PWR_CTRL: d.pwr_ctrl = q.shreg[1:0];
									mmt_pkg::A_MASK_LOS: d.mask.los = q.shreg[3:0];
									mmt_pkg::A_MASK_TX:  d.mask.tx_fault = q.shreg[3:0];
									mmt_pkg::A_MASK_ALM: d.mask.alarm = q.shreg;
									mmt_pkg::A_PAGE_SEL: d.page = q.shreg;
									default: begin
									end
								endcase
							end else if (q.page == mmt_pkg::PAGE_USER) begin
								d.user_mem[q.ptr[6:0]] = q.shreg;
							end
						end
					end
				end
				mmt_pkg::S_ACKW: begin
					if (fall) begin
						d.bus_st  = mmt_pkg::S_WR;
						d.sda_oe  = 1'b0;
						d.bit_cnt = '0;
					end
				end
				mmt_pkg::S_RD: begin
					if (rise) begin
						d.bit_cnt = q.bit_cnt + 4'h1;
					end else if (fall) begin
						if (q.bit_cnt == mmt_pkg::BITS_BYTE) begin
							d.bus_st = mmt_pkg::S_ACKR;
							d.sda_oe = 1'b0;
							d.ptr    = q.ptr + 8'h01;
							unique case (q.ptr)
								mmt_pkg::A_STATUS:   d.stat_rd = 1'b1;
								mmt_pkg::A_FLAG_LOS: d.clr.los = q.flags.los;
								mmt_pkg::A_FLAG_TX:  d.clr.tx_fault = q.flags.tx_fault;
								mmt_pkg::A_FLAG_ALM: d.clr.alarm = q.flags.alarm;
								default: begin
								end
							endcase
						end else begin
							d.shreg  = {q.shreg[6:0], 1'b0};
							d.sda_oe = ~q.shreg[6];
						end
					end
				end
				mmt_pkg::S_ACKR: begin
					if (rise) begin
						if (q.sda_s) begin
							d.bus_st = mmt_pkg::S_IDLE;
						end else begin
							d.bit_cnt = '0;
						end
					end else if (fall && q.bit_cnt == '0) begin
						d.bus_st = mmt_pkg::S_RD;
						d.shreg  = rdv;
						d.sda_oe = ~rdv[7];
					end
				end
			endcase
		end
		// open-drain: only ever pulls low
		d.sda_out = 1'b0;
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			q <= RST_STATE;
		end else begin
			q <= d;
		end
	end

	assign o_sda_out         = q.sda_out;
	assign o_sda_oe          = q.sda_oe;
	assign o_interrupt_out_n = q.intr_n;
	assign o_low_power       = q.low_pwr;
	assign o_ready           = q.ready;

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	property p_init_intr;
		$rose(q.ready) && !q.busy |=> !o_interrupt_out_n && !stat_byte[0];
	endproperty
	a_init_intr: assert property (p_init_intr) else $error("init end without interrupt");

	property p_rst_filter;
		q.rst_cnt == mmt_pkg::RST_MIN_CYC |=> q.busy ##1 !q.ready;
	endproperty
	a_rst_filter: assert property (p_rst_filter) else $error("long reset low not taken");

	property p_busy_notready;
		q.busy |=> !o_ready;
	endproperty
	a_busy_notready: assert property (p_busy_notready) else $error("ready during reset");

	property p_lp_pin;
		$rose(q.lp_s) |=> o_low_power;
	endproperty
	a_lp_pin: assert property (p_lp_pin) else $error("low-power pin ignored");

	property p_pdown;
		q.pwr_ctrl == 2'h3 |=> o_low_power;
	endproperty
	a_pdown: assert property (p_pdown) else $error("power-down bit ignored");

	property p_los_flag;
		!q.busy && q.cond_s.los[0] |=> q.flags.los[0];
	endproperty
	a_los_flag: assert property (p_los_flag) else $error("loss flag not set");

	property p_tx_flag;
		!q.busy && q.cond_s.tx_fault[0] |=> q.flags.tx_fault[0];
	endproperty
	a_tx_flag: assert property (p_tx_flag) else $error("fault flag not set");

	property p_intr_hold;
		|(q.flags & ~q.mask) |=> !o_interrupt_out_n;
	endproperty
	a_intr_hold: assert property (p_intr_hold) else $error("interrupt dropped with flag set");

	property p_intr_release;
		!(|(q.flags & ~q.mask)) && !q.init_pend |=> o_interrupt_out_n;
	endproperty
	a_intr_release: assert property (p_intr_release) else $error("interrupt stuck");

	property p_sel_ack;
		q.bus_st == mmt_pkg::S_ACKA && $past(q.bus_st) == mmt_pkg::S_ADDR |-> $past(sel) && o_sda_oe;
	endproperty
	a_sel_ack: assert property (p_sel_ack) else $error("ack while deselected");

	c_ack:   cover property (q.bus_st == mmt_pkg::S_ACKA);
	c_rdack: cover property (q.bus_st == mmt_pkg::S_ACKR ##1 q.bus_st == mmt_pkg::S_RD);
	c_clear: cover property (stop && |q.clr);
	c_init:  cover property ($rose(q.ready));

endmodule : mmt_ctrl

// ==== src/mmt_pkg.sv ====
/*
 * Constants, carrier types and the state record of the module management timing control block.
 * Assumes a 40 MHz system clock and a host on the 2-wire serial bus and sideband pins.
 */
// Overview of operation
// - byte 220 reports diagnostic monitoring type
// - byte 221 reports enhanced option bits
// - byte 223 checks bytes 192-222; 222 reserved
// - user page holds free-format bytes
// - fully functional within 2000 ms after reset
// - reset pin low over 2 us resets
// - serial bus answers within 2000 ms
// - init end clears not-ready, asserts interrupt
// - low-power pin enters low power quickly
// - interrupt output asserted within 200 ms
// - flags clear on read, interrupt releases
// - loss of signal sets flag, interrupt
// - transmit fault sets flag, interrupt
// - other conditions set flag, interrupt
// - mask bits gate flags off interrupt
// - module select gates bus responses
// - power-down bit enters and leaves low power; a high low-power pin still holds low power
// - write timings counted from stop
// - bus address is 1010000 plus direction
// - page select byte at 127 picks upper page
package mmt_pkg;

	// ------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------
	localparam int                 CLK_NS       = 25;
	localparam int                 NS_PER_MS    = 1000000;
	localparam int                 T_INIT_MS    = 2000;
	localparam int                 T_RST_MIN_NS = 2000;
	localparam int                 RST_CNT_W    = 8;
	localparam logic [RST_CNT_W-1:0] RST_MIN_CYC = RST_CNT_W'((T_RST_MIN_NS + CLK_NS - 1) / CLK_NS);
	localparam int                 INIT_W       = 27;

	// ------------------------------------------------------------------
	// bus address and register map
	// ------------------------------------------------------------------
	localparam logic [6:0] DEV_ADDR    = 7'h50;
	localparam logic [7:0] A_STATUS    = 8'h02;
	localparam logic [7:0] A_FLAG_LOS  = 8'h03;
	localparam logic [7:0] A_FLAG_TX   = 8'h04;
	localparam logic [7:0] A_FLAG_ALM  = 8'h05;
	localparam logic [7:0] A_PWR_CTRL  = 8'h5d;
	localparam logic [7:0] A_MASK_LOS  = 8'h64;
	localparam logic [7:0] A_MASK_TX   = 8'h65;
	localparam logic [7:0] A_MASK_ALM  = 8'h66;
	localparam logic [7:0] A_PAGE_SEL  = 8'h7f;
	localparam logic [7:0] A_EXT_ID_LO = 8'hc0;
	localparam logic [7:0] A_DIAG_TYPE = 8'hdc;
	localparam logic [7:0] A_ENH_OPTS  = 8'hdd;
	localparam logic [7:0] A_RSVD_ID   = 8'hde;
	localparam logic [7:0] A_EXT_CSUM  = 8'hdf;
	localparam logic [7:0] PAGE_ID     = 8'h00;
	localparam logic [7:0] PAGE_USER   = 8'h02;
	localparam int         EXT_LOW_N   = 28;
	localparam int         USER_N      = 128;
	localparam int         BIT_PWR_OVR = 0;
	localparam int         BIT_PWR_SET = 1;
	localparam logic [3:0] BITS_BYTE   = 4'h8;

	// ------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [3:0] los;
		logic [3:0] tx_fault;
		logic [7:0] alarm;
	} mmt_cond_t;

	typedef enum logic [6:0] {
		S_IDLE = 7'h01,
		S_ADDR = 7'h02,
		S_ACKA = 7'h04,
		S_WR   = 7'h08,
		S_ACKW = 7'h10,
		S_RD   = 7'h20,
		S_ACKR = 7'h40
	} mmt_bus_st_t;

	typedef struct packed {
		logic                         scl_m, scl_s, scl_p;
		logic                         sda_m, sda_s, sda_p;
		logic                         rstn_m, rstn_s;
		logic                         mseln_m, mseln_s;
		logic                         lp_m, lp_s;
		mmt_cond_t                    cond_m, cond_s;
		logic [RST_CNT_W-1:0]         rst_cnt;
		logic                         busy;
		logic [INIT_W-1:0]            init_cnt;
		logic                         ready;
		logic                         init_pend;
		logic                         stat_rd;
		mmt_bus_st_t                  bus_st;
		logic [3:0]                   bit_cnt;
		logic [7:0]                   shreg;
		logic                         rw;
		logic                         first;
		logic [7:0]                   ptr;
		logic [7:0]                   page;
		mmt_cond_t                    flags, mask, clr;
		logic [1:0]                   pwr_ctrl;
		logic                         intr_n;
		logic                         low_pwr;
		logic                         sda_oe;
		logic                         sda_out;
		logic [USER_N-1:0][7:0]       user_mem;
	} mmt_state_t;

endpackage : mmt_pkg

// ==== test/mmt_host_model.sv ====
/*
 * Host model for the 2-wire management bus: start, stop, byte transfer and register access tasks.
 * Assumes the bench resolves the open-drain data line with a pull-up and paces it by i_mclk.
 */
`timescale 1ns/1ps
module mmt_host_model (
	input  wire logic i_mclk,   // design clock, pacing only
	input  wire logic i_sda,    // resolved data line
	output logic      o_scl,    // bus clock, high when idle
	output logic      o_sda_oe  // high pulls data low
);
	// ------------------------------------------------------------------
	// bit timing
	// ------------------------------------------------------------------
	// quarter period well above the design's synchronizer lag, else acks land late
	localparam int Q = 10;

	initial begin
		o_scl    = 1'b1;
		o_sda_oe = 1'b0;
	end

	task automatic q();
		repeat (Q) @(negedge i_mclk);
	endtask : q

	task automatic start_c();
		o_sda_oe = 1'b0;
		q();
		o_scl = 1'b1;
		q();
		o_sda_oe = 1'b1;
		q();
		o_scl = 1'b0;
		q();
	endtask : start_c

	task automatic stop_c();
		o_sda_oe = 1'b1;
		q();
		o_scl = 1'b1;
		q();
		o_sda_oe = 1'b0;
		q();
	endtask : stop_c

	task automatic bit_c(input logic b, output logic r);
		o_sda_oe = ~b;
		q();
		o_scl = 1'b1;
		q();
		r = i_sda;
		q();
		o_scl = 1'b0;
		q();
	endtask : bit_c

	task automatic send(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_c(b[i], r);
		end
		bit_c(1'b1, r);
		ack = ~r;
	endtask : send

	task automatic recv(input logic last, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_c(1'b1, r);
			b[i] = r;
		end
		bit_c(last, r);
	endtask : recv

	// ------------------------------------------------------------------
	// register access
	// ------------------------------------------------------------------
	// address, then pointer
	task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d, output logic ack);
		logic a;
		start_c();
		send({dev, 1'b0}, ack);
		send(ptr, a);
		send(d, a);
		stop_c();
	endtask : wr

	task automatic rd(input logic [6:0] dev, input logic [7:0] ptr, output logic [7:0] d, output logic ack);
		logic a;
		start_c();
		send({dev, 1'b0}, ack);
		send(ptr, a);
		start_c();
		send({dev, 1'b1}, a);
		recv(1'b1, d);
		stop_c();
	endtask : rd
endmodule : mmt_host_model

// ==== test/mmt_ctrl_test.sv ====
/*
 * Self-checking testbench of the management control block with a host model on the 2-wire bus.
 * Assumes a shortened init count; all sideband pins are driven at the falling clock edge.
 */
`timescale 1ns/1ps
module mmt_ctrl_test;
	localparam int                                INIT_CYC = 4000;
	localparam logic [7:0]                        DIAG     = 8'h5a;
	localparam logic [7:0]                        ENH      = 8'hc3;
	localparam logic [mmt_pkg::EXT_LOW_N-1:0][7:0] EXT_ID  = {14{16'h3c07}};
	localparam logic [6:0]                        DEV      = mmt_pkg::DEV_ADDR;

	logic               mclk, rst, rstn_pin, msel_n, lp_pin;
	logic               scl, host_oe, dut_out, dut_oe, int_n, low_pwr, ready;
	mmt_pkg::mmt_cond_t cond;
	wire logic          sda;
	int                 fails = 0;
	int                 total_checks = 0;

	// pull-up: line low only while someone drives it
	assign sda = ~(host_oe | (dut_oe & ~dut_out));

	mmt_ctrl #(.INIT_CYC(INIT_CYC), .DIAG_TYPE(DIAG), .ENH_OPTS(ENH), .EXT_ID_LOW(EXT_ID)) dut (
		.i_mclk(mclk), .i_rst(rst), .i_reset_n_pin(rstn_pin), .i_module_select_n(msel_n),
		.i_low_power_pin(lp_pin), .i_cond(cond), .i_scl(scl), .i_sda_in(sda), .o_sda_out(dut_out),
		.o_sda_oe(dut_oe), .o_interrupt_out_n(int_n), .o_low_power(low_pwr), .o_ready(ready));

	mmt_host_model host (.i_mclk(mclk), .i_sda(sda), .o_scl(scl), .o_sda_oe(host_oe));

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("FAIL at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask : cyc

	task automatic wait_ready();
		for (int i = 0; i < INIT_CYC + 500 && ready !== 1'b1; i++) @(negedge mclk);
	endtask : wait_ready

	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : complete_run

	initial begin
		repeat (90000) @(posedge mclk);
		fails++;
		complete_run();
	end

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_init();
		logic [7:0] d;
		logic       ack;
		chk(ready, 1'b0);
		host.rd(DEV, mmt_pkg::A_STATUS, d, ack);
		chk(ack, 1'b1);
		chk(d & 8'h01, 8'h01);
		wait_ready();
		chk(ready, 1'b1);
		cyc(2);
		chk(int_n, 1'b0);
		host.rd(DEV, mmt_pkg::A_STATUS, d, ack);
		chk(d & 8'h01, 8'h00);
		cyc(10);
		chk(int_n, 1'b1);
	endtask : t_init

	task automatic t_id();
		logic [7:0] d;
		logic [7:0] exp [4];
		logic       ack;
		int         s;
		s = DIAG + ENH;
		for (int i = 0; i < mmt_pkg::EXT_LOW_N; i++) s += EXT_ID[i];
		exp = '{DIAG, ENH, 8'h00, 8'(s)};
		host.wr(DEV, mmt_pkg::A_PAGE_SEL, mmt_pkg::PAGE_ID, ack);
		host.wr(DEV, mmt_pkg::A_DIAG_TYPE, 8'hff, ack);
		for (int i = 0; i < 4; i++) begin
			host.rd(DEV, mmt_pkg::A_DIAG_TYPE + 8'(i), d, ack);
			chk(d, exp[i]);
		end
	endtask : t_id

	task automatic t_user();
		logic [7:0] d;
		logic       ack;
		host.wr(DEV, mmt_pkg::A_PAGE_SEL, mmt_pkg::PAGE_USER, ack);
		host.wr(DEV, 8'h80, 8'ha5, ack);
		host.wr(DEV, 8'hff, 8'h3c, ack);
		host.rd(DEV, 8'h80, d, ack);
		chk(d, 8'ha5);
		host.rd(DEV, 8'hff, d, ack);
		chk(d, 8'h3c);
		host.wr(DEV, mmt_pkg::A_PAGE_SEL, mmt_pkg::PAGE_ID, ack);
	endtask : t_user

	task automatic t_flags();
		logic [15:0] cv [3] = '{16'h2000, 16'h0800, 16'h0080};
		logic [7:0]  fx [3] = '{8'h02, 8'h08, 8'h80};
		logic [7:0]  d;
		logic        ack;
		for (int k = 0; k < 3; k++) begin
			cond = mmt_pkg::mmt_cond_t'(cv[k]);
			cyc(10);
			chk(int_n, 1'b0);
			cond = '0;
			cyc(10);
			chk(int_n, 1'b0);
			host.rd(DEV, mmt_pkg::A_FLAG_LOS + 8'(k), d, ack);
			chk(d, fx[k]);
			cyc(20);
			chk(int_n, 1'b1);
			host.rd(DEV, mmt_pkg::A_FLAG_LOS + 8'(k), d, ack);
			chk(d, 8'h00);
		end
	endtask : t_flags

	task automatic t_mask();
		logic [15:0] cv [3] = '{16'h1000, 16'h0400, 16'h0001};
		logic [7:0]  fx [3] = '{8'h01, 8'h04, 8'h01};
		logic [7:0]  mk [3] = '{8'h0f, 8'h0f, 8'hff};
		logic [7:0]  d;
		logic        ack;
		// every mask byte: readback, inhibit, resume
		for (int k = 0; k < 3; k++) begin
			host.wr(DEV, mmt_pkg::A_MASK_LOS + 8'(k), 8'hff, ack);
			host.rd(DEV, mmt_pkg::A_MASK_LOS + 8'(k), d, ack);
			chk(d, mk[k]);
			cond = mmt_pkg::mmt_cond_t'(cv[k]);
			cyc(10);
			chk(int_n, 1'b1);
			host.wr(DEV, mmt_pkg::A_MASK_LOS + 8'(k), 8'h00, ack);
			cyc(10);
			chk(int_n, 1'b0);
			cond = '0;
			host.rd(DEV, mmt_pkg::A_FLAG_LOS + 8'(k), d, ack);
			chk(d, fx[k]);
			cyc(20);
			chk(int_n, 1'b1);
		end
	endtask : t_mask

	task automatic t_select();
		logic [7:0] d;
		logic       ack;
		msel_n = 1'b1;
		cyc(10);
		host.rd(DEV, mmt_pkg::A_STATUS, d, ack);
		chk(ack, 1'b0);
		msel_n = 1'b0;
		cyc(10);
		host.rd(DEV, mmt_pkg::A_STATUS, d, ack);
		chk(ack, 1'b1);
		host.rd(DEV ^ 7'h01, mmt_pkg::A_STATUS, d, ack);
		chk(ack, 1'b0);
	endtask : t_select

	task automatic t_power();
		logic ack;
		lp_pin = 1'b1;
		cyc(6);
		chk(low_pwr, 1'b1);
		lp_pin = 1'b0;
		cyc(6);
		chk(low_pwr, 1'b0);
		host.wr(DEV, mmt_pkg::A_PWR_CTRL, 8'h01, ack);
		cyc(2);
		chk(low_pwr, 1'b0);
		host.wr(DEV, mmt_pkg::A_PWR_CTRL, 8'h03, ack);
		cyc(2);
		chk(low_pwr, 1'b1);
		host.wr(DEV, mmt_pkg::A_PWR_CTRL, 8'h00, ack);
		cyc(2);
		chk(low_pwr, 1'b0);
	endtask : t_power

	task automatic t_reset_pin();
		logic [7:0] d;
		logic       ack;
		rstn_pin = 1'b0;
		cyc(40);
		rstn_pin = 1'b1;
		cyc(10);
		chk(ready, 1'b1);
		rstn_pin = 1'b0;
		cyc(120);
		chk(ready, 1'b0);
		rstn_pin = 1'b1;
		wait_ready();
		chk(ready, 1'b1);
		cyc(2);
		chk(int_n, 1'b0);
		host.rd(DEV, mmt_pkg::A_STATUS, d, ack);
		cyc(10);
		chk(int_n, 1'b1);
	endtask : t_reset_pin

	initial begin
		rst      = 1'b1;
		rstn_pin = 1'b1;
		msel_n   = 1'b0;
		lp_pin   = 1'b0;
		cond     = '0;
		repeat (3) @(negedge mclk);
		rst = 1'b0;
		t_init();
		t_id();
		t_user();
		t_flags();
		t_mask();
		t_select();
		t_power();
		t_reset_pin();
		complete_run();
	end
endmodule : mmt_ctrl_test
